// file: uei_pkg.sv
package uei_pkg;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_B0_PTR   = 12'h000;
    localparam logic [11:0] IDX_B0_SIZE  = 12'h004;
    localparam logic [11:0] IDX_B1_PTR   = 12'h010;
    localparam logic [11:0] IDX_B1_SIZE  = 12'h014;
    localparam logic [11:0] IDX_EN_CLR   = 12'h108;
    localparam logic [11:0] IDX_EN_SET   = 12'h109;
    localparam logic [11:0] IDX_STATUS   = 12'h10a;
    localparam logic [11:0] IDX_CTRL     = 12'h10b;
    localparam int          ADDR_W       = 14;

    // endpoint event and enable bit positions
    localparam int BIT_DONE0  = 0;
    localparam int BIT_DONE1  = 1;
    localparam int BIT_FAIL0  = 2;
    localparam int BIT_FAIL1  = 3;
    localparam int BIT_SETUP  = 4;
    localparam int BIT_STALL_BANK0 = 5;
    localparam int BIT_STALL_BANK1 = 6;
    localparam int EV_W       = 7;

    // control register layout
    localparam int BIT_EP_ACTIVE = 0;

    // packet size word layout
    localparam int ZLP_BIT   = 31;
    localparam int SIZE_LSB  = 28;
    localparam int SIZE_W    = 3;
    localparam int MPS_LSB   = 14;
    localparam int CNT_W     = 14;
    localparam int BC_LSB    = 0;
    localparam int PTR_LSB   = 2;

    // reset values
    localparam logic [31:0]     DESC_RST = 32'h0000_0000;
    localparam logic [EV_W-1:0] EV_RST   = 7'h00;
    localparam logic [7:0]      CTRL_RST = 8'h00;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // size code to maximum packet length in bytes
    function automatic logic [10:0] uei_size_len(input logic [SIZE_W-1:0] code);
        logic [10:0] len;
        len = 11'h008;
        unique case (code)
            3'h0: len = 11'h008;
            3'h1: len = 11'h010;
            3'h2: len = 11'h020;
            3'h3: len = 11'h040;
            3'h4: len = 11'h080;
            3'h5: len = 11'h100;
            3'h6: len = 11'h200;
            3'h7: len = 11'h3ff;
        endcase
        return len;
    endfunction : uei_size_len

endpackage : uei_pkg

// file: uei_bank_desc.sv
// one bank descriptor: buffer pointer word and packet size word
module uei_bank_desc
    import uei_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // software writes
    input  wire logic              wr_ptr,
    input  wire logic              wr_size,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    // transfer engine updates
    input  wire logic              in_sent,
    input  wire logic              out_recv,
    input  wire logic [CNT_W-1:0]  xfer_count,
    // read back
    output logic      [31:0]       ptr_word,
    output logic      [31:0]       size_word,
    // decoded fields
    output logic      [31:0]       buf_addr,
    output logic      [10:0]       max_pkt_len,
    output logic                   auto_zero_length_packet,
    output logic      [CNT_W-1:0]  multi_pkt,
    output logic      [CNT_W-1:0]  byte_count
);

    logic [31:0]      ptr_r;     // buffer pointer, low bits forced zero
    logic [31:0]      ptr_nxt;
    logic [31:0]      size_r;    // packet size word
    logic [31:0]      size_nxt;
    logic [CNT_W-1:0] mps_sum;   // accumulated multi-packet count

    // byte-lane merge of software writes, then engine updates
    always_comb begin
        ptr_nxt  = ptr_r;
        size_nxt = size_r;
        for (int i = 0; i < 4; i++) begin
            if (wr_ptr && wstrb[i]) begin
                ptr_nxt[i*8 +: 8] = wdata[i*8 +: 8];
            end
            if (wr_size && wstrb[i]) begin
                size_nxt[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        // low pointer bits are read only, keeps the buffer word aligned
        ptr_nxt[PTR_LSB-1:0] = 2'h0;
        // in endpoints add the bytes just sent to the running total
        mps_sum = size_nxt[MPS_LSB +: CNT_W] + xfer_count;
        if (in_sent) begin
            size_nxt[MPS_LSB +: CNT_W] = mps_sum;
        end
        // out or setup endpoints record what arrived
        if (out_recv) begin
            size_nxt[BC_LSB +: CNT_W] = xfer_count;
        end
    end

    // descriptor storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr_r  <= DESC_RST;
            size_r <= DESC_RST;
        end else begin
            ptr_r  <= ptr_nxt;
            size_r <= size_nxt;
        end
    end

    assign ptr_word    = ptr_r;
    assign size_word   = size_r;
    assign buf_addr    = ptr_r;
    assign max_pkt_len = uei_size_len(size_r[SIZE_LSB +: SIZE_W]);
    assign auto_zero_length_packet    = size_r[ZLP_BIT];
    assign multi_pkt   = size_r[MPS_LSB +: CNT_W];
    assign byte_count  = size_r[BC_LSB +: CNT_W];

endmodule : uei_bank_desc

// file: uei_endpoint.sv
// How it works
// - clear view one disables transfer done bank0
// - enabled done bank0 flag raises interrupt
// - set view one enables, zero ignored
// - both views share one enable state
// - bus reset or inactive endpoint clears enables
// - top enable bit reads zero, writes ignored
// - auto zero length packet bit, in only
// - size code selects maximum packet length
// - fourteen bit multi packet length field
// - in endpoints accumulate bytes sent
// - byte count next in or last received
//
// Decided for this implementation: the AXI4-Lite slave port.
module uei_endpoint
    import uei_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // usb link events
    input  wire logic              usb_bus_reset,
    input  wire logic [EV_W-1:0]   ep_event,
    // transfer engine updates, one bit per bank
    input  wire logic [1:0]        bank_in_sent,
    input  wire logic [1:0]        bank_out_recv,
    input  wire logic [CNT_W-1:0]  xfer_count,
    // descriptor fields to the transfer engine
    output logic      [31:0]       bank0_buf_addr,
    output logic      [10:0]       bank0_max_len,
    output logic                   bank0_auto_zero_length_packet,
    output logic      [CNT_W-1:0]  bank0_multi_pkt,
    output logic      [CNT_W-1:0]  bank0_byte_count,
    output logic      [31:0]       bank1_buf_addr,
    output logic      [10:0]       bank1_max_len,
    output logic                   bank1_auto_zero_length_packet,
    output logic      [CNT_W-1:0]  bank1_multi_pkt,
    output logic      [CNT_W-1:0]  bank1_byte_count,
    // endpoint state and interrupt
    output logic                   endpoint_active,
    output logic                   irq
);

    // write channel holding state
    logic              aw_held_r;    // address taken, waiting for data
    logic              aw_held_nxt;
    logic [ADDR_W-1:0] awaddr_r;     // held write address
    logic [ADDR_W-1:0] awaddr_nxt;
    logic              w_held_r;     // data taken, waiting for address
    logic              w_held_nxt;
    logic [31:0]       wdata_r;      // held write data
    logic [31:0]       wdata_nxt;
    logic [3:0]        wstrb_r;      // held byte strobes
    logic [3:0]        wstrb_nxt;
    logic              bvalid_r;     // write response pending
    logic              bvalid_nxt;
    logic [1:0]        bresp_r;      // write response code
    logic [1:0]        bresp_nxt;

    // read channel state
    logic              rvalid_r;     // read data pending
    logic              rvalid_nxt;
    logic [31:0]       rdata_r;      // read data
    logic [31:0]       rdata_nxt;
    logic [1:0]        rresp_r;      // read response code
    logic [1:0]        rresp_nxt;

    // endpoint registers
    logic [EV_W-1:0]   enable_r;     // shared interrupt enable state
    logic [EV_W-1:0]   enable_nxt;
    logic [EV_W-1:0]   status_r;     // sticky event bits
    logic [EV_W-1:0]   status_nxt;
    logic [7:0]        ctrl_r;       // control, bit 0 activates endpoint
    logic [7:0]        ctrl_nxt;

    // decode
    logic              wr_go;        // both halves held, commit write
    logic [11:0]       wr_idx;       // write register index
    logic [11:0]       rd_idx;       // read register index
    logic              rd_go;        // read address handshake
    logic              wr_b0_ptr;
    logic              wr_b0_size;
    logic              wr_b1_ptr;
    logic              wr_b1_size;
    logic              wr_en_set;
    logic              wr_en_clr;
    logic              wr_ctrl;
    logic              wr_hit;       // write lands on a mapped register
    logic              rd_status;    // read of the status register clears it

    // bank read-back words
    logic [31:0]       b0_ptr_word;
    logic [31:0]       b0_size_word;
    logic [31:0]       b1_ptr_word;
    logic [31:0]       b1_size_word;

    // handshakes: one write and one read at a time, no skid buffer
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign wr_go  = aw_held_r && w_held_r && !bvalid_r;
    assign rd_go  = s_axi_arvalid && !rvalid_r;
    assign wr_idx = awaddr_r[ADDR_W-1:2];
    assign rd_idx = s_axi_araddr[ADDR_W-1:2];

    // register select; bank words sit at their fixed descriptor offsets
    assign wr_b0_ptr  = wr_go && (wr_idx == IDX_B0_PTR);
    assign wr_b0_size = wr_go && (wr_idx == IDX_B0_SIZE);
    assign wr_b1_ptr  = wr_go && (wr_idx == IDX_B1_PTR);
    assign wr_b1_size = wr_go && (wr_idx == IDX_B1_SIZE);
    assign wr_en_set  = wr_go && (wr_idx == IDX_EN_SET) && wstrb_r[0];
    assign wr_en_clr  = wr_go && (wr_idx == IDX_EN_CLR) && wstrb_r[0];
    assign wr_ctrl    = wr_go && (wr_idx == IDX_CTRL) && wstrb_r[0];
    assign wr_hit     = (wr_idx == IDX_B0_PTR) || (wr_idx == IDX_B0_SIZE) ||
                        (wr_idx == IDX_B1_PTR) || (wr_idx == IDX_B1_SIZE) ||
                        (wr_idx == IDX_EN_SET) || (wr_idx == IDX_EN_CLR) ||
                        (wr_idx == IDX_STATUS) || (wr_idx == IDX_CTRL);
    assign rd_status  = rd_go && (rd_idx == IDX_STATUS);

    // write channel next state
    always_comb begin
        aw_held_nxt = aw_held_r;
        awaddr_nxt  = awaddr_r;
        w_held_nxt  = w_held_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        // address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
        end
        // commit, then answer; unmapped writes get slverr and no effect
        if (wr_go) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // read channel next state
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            unique case (rd_idx)
                IDX_B0_PTR:  rdata_nxt = b0_ptr_word;
                IDX_B0_SIZE: rdata_nxt = b0_size_word;
                IDX_B1_PTR:  rdata_nxt = b1_ptr_word;
                IDX_B1_SIZE: rdata_nxt = b1_size_word;
                // both views read the same state, top bit zero
                IDX_EN_SET:  rdata_nxt = {25'h0, enable_r};
                IDX_EN_CLR:  rdata_nxt = {25'h0, enable_r};
                IDX_STATUS:  rdata_nxt = {25'h0, status_r};
                IDX_CTRL:    rdata_nxt = {24'h0, ctrl_r};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // bus channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= '0;
            w_held_r  <= 1'b0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            awaddr_r  <= awaddr_nxt;
            w_held_r  <= w_held_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    // endpoint register next state
    always_comb begin
        ctrl_nxt   = ctrl_r;
        enable_nxt = enable_r;
        if (wr_ctrl) begin
            ctrl_nxt = {7'h00, wdata_r[BIT_EP_ACTIVE]};
        end
        // one bits act, zero bits and the reserved top bit are ignored
        if (wr_en_set) begin
            enable_nxt = enable_nxt | wdata_r[EV_W-1:0];
        end
        if (wr_en_clr) begin
            enable_nxt = enable_nxt & ~wdata_r[EV_W-1:0];
        end
        // bus reset or an inactive endpoint wipes every enable
        if (usb_bus_reset || !ctrl_r[BIT_EP_ACTIVE]) begin
            enable_nxt = EV_RST;
        end
        // sticky events; a new event beats the read that clears
        status_nxt = (rd_status ? EV_RST : status_r) | ep_event;
    end

    // endpoint registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r   <= CTRL_RST;
            enable_r <= EV_RST;
            status_r <= EV_RST;
        end else begin
            ctrl_r   <= ctrl_nxt;
            enable_r <= enable_nxt;
            status_r <= status_nxt;
        end
    end

    // level interrupt while any enabled event is pending
    assign irq             = |(status_r & enable_r);
    assign endpoint_active = ctrl_r[BIT_EP_ACTIVE];

    // bank 0 descriptor
    uei_bank_desc u_bank0 (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .wr_ptr      (wr_b0_ptr),
        .wr_size     (wr_b0_size),
        .wdata       (wdata_r),
        .wstrb       (wstrb_r),
        .in_sent     (bank_in_sent[0]),
        .out_recv    (bank_out_recv[0]),
        .xfer_count  (xfer_count),
        .ptr_word    (b0_ptr_word),
        .size_word   (b0_size_word),
        .buf_addr    (bank0_buf_addr),
        .max_pkt_len (bank0_max_len),
        .auto_zero_length_packet    (bank0_auto_zero_length_packet),
        .multi_pkt   (bank0_multi_pkt),
        .byte_count  (bank0_byte_count)
    );

    // bank 1 descriptor
    uei_bank_desc u_bank1 (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .wr_ptr      (wr_b1_ptr),
        .wr_size     (wr_b1_size),
        .wdata       (wdata_r),
        .wstrb       (wstrb_r),
        .in_sent     (bank_in_sent[1]),
        .out_recv    (bank_out_recv[1]),
        .xfer_count  (xfer_count),
        .ptr_word    (b1_ptr_word),
        .size_word   (b1_size_word),
        .buf_addr    (bank1_buf_addr),
        .max_pkt_len (bank1_max_len),
        .auto_zero_length_packet    (bank1_auto_zero_length_packet),
        .multi_pkt   (bank1_multi_pkt),
        .byte_count  (bank1_byte_count)
    );

endmodule : uei_endpoint

// file: uei_endpoint_asserts.sv
// watches the endpoint block from its pins only
module uei_endpoint_chk
    import uei_pkg::*;
(
    // clock and reset
    input wire logic              aclk, aresetn,
    // bus handshakes
    input wire logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic              s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic [31:0]       s_axi_rdata,
    // link and engine side
    input wire logic              usb_bus_reset, endpoint_active, irq,
    input wire logic [1:0]        bank_in_sent, bank_out_recv,
    input wire logic [CNT_W-1:0]  xfer_count, bank0_multi_pkt, bank1_byte_count,
    input wire logic [31:0]       bank0_buf_addr, bank1_buf_addr
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // both halves of a write taken at one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // one quiet commit cycle, then the response
    sequence resp_after_commit;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    a_write_latency: assert property (wr_taken |=> resp_after_commit)
        else $error("write response not two edges after acceptance");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    a_bus_reset_quiet: assert property (usb_bus_reset |=> !irq)
        else $error("interrupt after link reset");
    a_inactive_quiet: assert property (!endpoint_active |=> !irq)
        else $error("interrupt from inactive endpoint");
    a_ptr_aligned: assert property (bank0_buf_addr[1:0] == 2'h0 && bank1_buf_addr[1:0] == 2'h0)
        else $error("buffer pointer not word aligned");
    a_multi_accum: assert property (bank_in_sent[0] |=>
        bank0_multi_pkt == $past(bank0_multi_pkt) + $past(xfer_count))
        else $error("sent byte total not accumulated");
    a_count_load: assert property (bank_out_recv[1] |=> bank1_byte_count == $past(xfer_count))
        else $error("received byte count not loaded");
endmodule : uei_endpoint_chk

bind uei_endpoint uei_endpoint_chk u_uei_endpoint_chk (.*);

// file: uei_host_model.sv
// far side: link events and the transfer engine, driven on command
module uei_host_model
    import uei_pkg::*;
(
    input  wire logic             aclk,
    output logic                  usb_bus_reset,
    output logic [EV_W-1:0]       ep_event,
    output logic [1:0]            bank_in_sent,
    output logic [1:0]            bank_out_recv,
    output logic [CNT_W-1:0]      xfer_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle link at time zero
    initial begin
        usb_bus_reset = 1'b0;
        ep_event      = 7'h00;
        bank_in_sent  = 2'h0;
        bank_out_recv = 2'h0;
        xfer_count    = 14'h0000;
    end

    // one cycle pulse of a single endpoint event
    task automatic event_hit(input int b);
        @(posedge aclk);
        ep_event <= 7'h01 << b;
        @(posedge aclk);
        ep_event <= 7'h00;
    endtask : event_hit

    // one cycle of link reset
    task automatic bus_reset();
        @(posedge aclk);
        usb_bus_reset <= 1'b1;
        @(posedge aclk);
        usb_bus_reset <= 1'b0;
    endtask : bus_reset

    // packet done on a bank after gap idle cycles (slow host when gap > 0)
    task automatic engine(input logic in_dir, input int bank, input logic [CNT_W-1:0] cnt,
                          input int gap);
        repeat (gap) @(posedge aclk);
        @(posedge aclk);
        if (in_dir) begin
            bank_in_sent[bank] <= 1'b1;
        end else begin
            bank_out_recv[bank] <= 1'b1;
        end
        xfer_count <= cnt;
        @(posedge aclk);
        bank_in_sent  <= 2'h0;
        bank_out_recv <= 2'h0;
        // count no longer held, so show something else
        xfer_count    <= ~cnt;
    endtask : engine
endmodule : uei_host_model

// file: tb_top.sv
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end

module tb_top
    import uei_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // design pins, named as its ports
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, usb_bus_reset, endpoint_active, irq, bank0_auto_zero_length_packet, bank1_auto_zero_length_packet;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, bank0_buf_addr, bank1_buf_addr, v;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp, bank_in_sent, bank_out_recv;
    logic [EV_W-1:0]   ep_event;
    logic [CNT_W-1:0]  xfer_count, bank0_multi_pkt, bank0_byte_count;
    logic [CNT_W-1:0]  bank1_multi_pkt, bank1_byte_count;
    logic [10:0]       bank0_max_len, bank1_max_len;
    // bench state: expected responses waiting for the monitor
    int                err_count = 0;
    int                tests_run = 0;
    int                cyc = 0;
    integer            seed = 32'h19d8e1f1;
    logic [1:0]        bq[$];
    logic [33:0]       rq[$];
    logic [10:0]       len_tab [8] = '{11'h008, 11'h010, 11'h020, 11'h040,
                                       11'h080, 11'h100, 11'h200, 11'h3ff};
    logic [11:0]       idx_tab [8] = '{IDX_B0_PTR, IDX_B0_SIZE, IDX_B1_PTR, IDX_B1_SIZE,
                                       IDX_EN_CLR, IDX_EN_SET, IDX_STATUS, IDX_CTRL};

    uei_endpoint   u_uei_endpoint (.*);
    uei_host_model u_uei_host_model (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // hang guard, far above the few hundred cycles needed
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    // monitor: oldest note against each response as it is handed over
    always @(negedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) `CHK(s_axi_bresp, bq.pop_front())
        if (s_axi_rvalid && s_axi_rready) `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
    end

    task automatic wrap_up();
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    function automatic logic [ADDR_W-1:0] ba(input logic [11:0] idx);
        return {idx, 2'b00};
    endfunction : ba

    // one write; halves released separately as each is taken
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d  = 1'b0;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(negedge aclk);
            aw_d = aw_d | (s_axi_awvalid && s_axi_awready);
            w_d  = w_d | (s_axi_wvalid && s_axi_wready);
            @(posedge aclk);
            if (aw_d) s_axi_awvalid <= 1'b0;
            if (w_d) s_axi_wvalid <= 1'b0;
        end while (!(aw_d && w_d));
        do @(negedge aclk); while (!s_axi_bvalid);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr

    // one read; the monitor checks the data
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        s_axi_awaddr = 14'h0000;
        s_axi_araddr = 14'h0000;
        s_axi_wdata  = 32'h0000_0000;
        s_axi_wstrb  = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // every register clear out of reset, unmapped place refused
        foreach (idx_tab[i]) rd(ba(idx_tab[i]), 32'h0, RESP_OKAY);
        `CHK(bank0_max_len, 11'h008)
        rd(ba(12'h0ff), 32'h0, RESP_SLVERR);
        wr(ba(12'h0ff), 32'hffff_ffff, RESP_SLVERR);
        // enables cannot be set on an inactive endpoint
        wr(ba(IDX_EN_SET), 32'h7f, RESP_OKAY);
        rd(ba(IDX_EN_SET), 32'h0, RESP_OKAY);
        wr(ba(IDX_CTRL), 32'h1, RESP_OKAY);
        `CHK(endpoint_active, 1'b1)
        wr(ba(IDX_EN_SET), 32'hff, RESP_OKAY);
        rd(ba(IDX_EN_CLR), 32'h7f, RESP_OKAY);
        wr(ba(IDX_EN_CLR), 32'h01, RESP_OKAY);
        wr(ba(IDX_EN_SET), 32'h00, RESP_OKAY);
        rd(ba(IDX_EN_SET), 32'h7e, RESP_OKAY);
        u_uei_host_model.bus_reset();
        rd(ba(IDX_EN_SET), 32'h0, RESP_OKAY);
        // each event: masked first, then enabled, then cleared by reading
        for (int b = 0; b < EV_W; b++) begin
            wr(ba(IDX_EN_CLR), 32'h7f, RESP_OKAY);
            u_uei_host_model.event_hit(b);
            @(negedge aclk);
            `CHK(irq, 1'b0)
            wr(ba(IDX_EN_SET), 32'h1 << b, RESP_OKAY);
            @(negedge aclk);
            `CHK(irq, 1'b1)
            rd(ba(IDX_STATUS), 32'h1 << b, RESP_OKAY);
            @(negedge aclk);
            `CHK(irq, 1'b0)
        end
        // enabled before the event, then the endpoint switched off
        wr(ba(IDX_EN_SET), 32'h01, RESP_OKAY);
        u_uei_host_model.event_hit(0);
        @(negedge aclk);
        `CHK(irq, 1'b1)
        wr(ba(IDX_CTRL), 32'h0, RESP_OKAY);
        @(negedge aclk);
        `CHK(irq, 1'b0)
        rd(ba(IDX_EN_SET), 32'h0, RESP_OKAY);
        rd(ba(IDX_STATUS), 32'h1, RESP_OKAY);
        // pointer low bits are read only
        v = $random(seed);
        wr(ba(IDX_B0_PTR), v | 32'h3, RESP_OKAY);
        rd(ba(IDX_B0_PTR), v & 32'hffff_fffc, RESP_OKAY);
        `CHK(bank0_buf_addr, v & 32'hffff_fffc)
        // every size code with random count fields
        for (int c = 0; c < 8; c++) begin
            v = {c[0], c[2:0], 28'($random(seed))};
            wr(ba(IDX_B1_SIZE), v, RESP_OKAY);
            rd(ba(IDX_B1_SIZE), v, RESP_OKAY);
            @(negedge aclk);
            `CHK({bank1_max_len, bank1_auto_zero_length_packet, bank1_multi_pkt, bank1_byte_count}, {len_tab[c], v[31], v[27:0]})
        end
        // in bank: total zeroed by firmware, then two packets, the second slow
        wr(ba(IDX_B0_SIZE), 32'h3000_0000, RESP_OKAY);
        u_uei_host_model.engine(1'b1, 0, 14'h0040, 0);
        u_uei_host_model.engine(1'b1, 0, 14'h0040, 3);
        @(negedge aclk);
        `CHK({bank0_byte_count, bank0_multi_pkt}, {14'h0000, 14'h0080})
        rd(ba(IDX_B0_SIZE), 32'h3020_0000, RESP_OKAY);
        // out bank: length a multiple of 64, received count loaded
        wr(ba(IDX_B1_SIZE), 32'h3020_0000, RESP_OKAY);
        u_uei_host_model.engine(1'b0, 1, 14'h0025, 1);
        @(negedge aclk);
        `CHK(bank1_byte_count, 14'h0025)
        rd(ba(IDX_B1_SIZE), 32'h3020_0025, RESP_OKAY);
        wrap_up();
    end
endmodule : tb_top
